// *** src/ulf_channel.sv ***
// Register decode, character format, shifters, break and baud output for one serial channel.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////////////
// Function
// (RULE_01) Access bit clear: offsets 0-2 normal; 3-7 fixed.
// (RULE_02) Access bit set: offsets 0,1 hit divisor.
// (RULE_03) Software clears access bit before offsets 0-2.
// (RULE_04) Bits 1:0 select five to eight data bits.
// (RULE_05) Bit 2: one, one-half-extra, or two stop bits.
// (RULE_06) Receiver checks only the first stop bit.
// (RULE_07) Bit 3 adds parity after last data bit.
// (RULE_08) Bit 4 selects even, else odd parity.
// (RULE_09) Stick parity forces bit to inverse of bit 4.
// (RULE_10) Bit 6 holds serial output low.
// (RULE_11) Break touches only the pin; shifter runs.
// (RULE_12) Baud output shown only with access bit set.
// (RULE_13) Software waits for idle flag around break.
// (RULE_14) Software may time break by sending characters.
// (RULE_15) Characters move least significant bit first.
// (RULE_16) Divisor 1..65535 makes the 16x baud tick.
// (RULE_17) High byte is divisor bits 15:8.
module ulf_channel
   import ulf_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [2:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic serial_in_line,
   output logic serial_out_line,
   output logic baud_clock_output,
   output logic holding_empty_flag,
   output logic transmitter_idle_flag
);
   ulf_bus_t bus;
   ulf_format_t fmt;
   logic [7:0] line_control;
   logic [7:0] interrupt_enable;
   logic [7:0] modem_control;
   logic [7:0] scratch_pad;
   logic [7:0] divisor_low_byte;
   logic [7:0] divisor_high_byte;
   logic [7:0] transmit_holding;
   logic [7:0] receive_buffer;
   logic [7:0] line_status;
   logic hold_full;
   logic data_ready;
   logic parity_err;
   logic framing_err;
   logic divisor_access_select;
   logic [15:0] divisor;
   logic [15:0] baud_count;
   logic baud_tick;
   logic baud_level;
   logic sin_meta;
   logic sin_sync;

   assign bus = '{addr: reg_addr, rd: reg_rd, wr: reg_wr, wdata: reg_wdata};
   assign divisor_access_select = line_control[LCR_DIV_ACCESS];
   assign divisor = {divisor_high_byte, divisor_low_byte}; // RULE_17

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Address decode.
   wire hit_div_low = divisor_access_select && (bus.addr == OFS_DATA); // RULE_02
   wire hit_div_high = divisor_access_select && (bus.addr == OFS_INT_ENABLE); // RULE_02
   wire hit_data = !divisor_access_select && (bus.addr == OFS_DATA); // RULE_01
   wire hit_int_en = !divisor_access_select && (bus.addr == OFS_INT_ENABLE); // RULE_01
   wire wr_thr = bus.wr && hit_data;
   wire rd_rbr = bus.rd && hit_data;
   wire wr_lcr = bus.wr && (bus.addr == OFS_LINE_CONTROL); // RULE_01
   wire wr_mcr = bus.wr && (bus.addr == OFS_MODEM_CONTROL);
   wire wr_scr = bus.wr && (bus.addr == OFS_SCRATCH);
   wire rd_lsr = bus.rd && (bus.addr == OFS_LINE_STATUS);

   assign line_status = {1'b0, transmitter_idle_flag, holding_empty_flag, 1'b0, framing_err,
                         parity_err, 1'b0, data_ready};

   logic [7:0] read_mux;
   always_comb
   begin
      case (bus.addr) // RULE_01
         OFS_DATA: read_mux = divisor_access_select ? divisor_low_byte : receive_buffer;
         OFS_INT_ENABLE: read_mux = divisor_access_select ? divisor_high_byte : interrupt_enable;
         OFS_INT_ID: read_mux = INT_ID_NONE;
         OFS_LINE_CONTROL: read_mux = line_control;
         OFS_MODEM_CONTROL: read_mux = modem_control;
         OFS_LINE_STATUS: read_mux = line_status;
         OFS_MODEM_STATUS: read_mux = 8'h00;
         OFS_SCRATCH: read_mux = scratch_pad;
         default: read_mux = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= read_mux;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         line_control <= RST_LINE_CONTROL;
         interrupt_enable <= RST_INT_ENABLE;
         modem_control <= RST_MODEM_CONTROL;
         scratch_pad <= RST_SCRATCH;
         divisor_low_byte <= RST_DIV_LOW;
         divisor_high_byte <= RST_DIV_HIGH;
      end
      else
      begin
         if (wr_lcr)
            line_control <= bus.wdata;
         if (bus.wr && hit_int_en)
            interrupt_enable <= {4'h0, bus.wdata[3:0]};
         if (wr_mcr)
            modem_control <= {3'h0, bus.wdata[4:0]};
         if (wr_scr)
            scratch_pad <= bus.wdata;
         if (bus.wr && hit_div_low)
            divisor_low_byte <= bus.wdata; // RULE_02
         if (bus.wr && hit_div_high)
            divisor_high_byte <= bus.wdata; // RULE_02
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Format decode shared by both directions.
   assign fmt.data_bits_m1 = 3'd4 + {1'b0, line_control[LCR_LEN_LO +: 2]}; // RULE_04
   assign fmt.parity_on = line_control[LCR_PAR_EN]; // RULE_07
   assign fmt.even = line_control[LCR_EVEN]; // RULE_08
   assign fmt.parity_bit_fixed = line_control[LCR_STICK]; // RULE_09
   assign fmt.fixed_value = !line_control[LCR_EVEN]; // RULE_09
   // Stop length in half bits minus two: 0 is one, 1 is one and a half, 2 is two.
   assign fmt.stop_halves_m2 = !line_control[LCR_STOP] ? 2'd0 :
                               (line_control[1:0] == 2'b00) ? 2'd1 : 2'd2; // RULE_05

   function automatic logic parity_of(input logic [7:0] d, input ulf_format_t f);
      logic [7:0] mask;
      mask = 8'hFF >> (3'd7 - f.data_bits_m1);
      if (f.parity_bit_fixed)
         parity_of = f.fixed_value; // RULE_09
      else
         parity_of = ^(d & mask) ^ !f.even; // RULE_08
   endfunction

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Baud generator. A divisor of zero is treated as one so the tick never stops.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         baud_count <= 16'h0000;
         baud_level <= 1'b0;
      end
      else if (baud_tick)
      begin
         baud_count <= 16'h0000;
         baud_level <= !baud_level;
      end
      else
         baud_count <= baud_count + 16'h0001;
   end
   assign baud_tick = (baud_count + 16'h0001 >= divisor); // RULE_16
   assign baud_clock_output = divisor_access_select & baud_level; // RULE_12

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Transmitter.
   typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} ulf_tx_state_t;
   ulf_tx_state_t tx_state;
   logic [7:0] tx_shift;
   logic [2:0] tx_bit;
   logic [3:0] tx_os;
   logic [1:0] tx_half;
   logic tx_line;
   logic tx_parity;

   wire tx_bit_end = baud_tick && (tx_os == OVERSAMPLE_LAST);
   wire tx_half_end = baud_tick && (tx_os == OVERSAMPLE_MID);
   wire tx_stop_go = (tx_state == TX_STOP) && (tx_bit_end || tx_half_end) &&
                     (tx_half == fmt.stop_halves_m2 + 2'h1); // RULE_05
   wire tx_load = hold_full && !wr_thr && ((tx_state == TX_IDLE && tx_bit_end) || tx_stop_go);

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         tx_state <= TX_IDLE;
         tx_shift <= 8'h00;
         tx_bit <= 3'd0;
         tx_os <= 4'h0;
         tx_half <= 2'd0;
         tx_line <= 1'b1;
         tx_parity <= 1'b0;
         hold_full <= 1'b0;
         transmit_holding <= 8'h00;
      end
      else
      begin
         if (wr_thr)
         begin
            transmit_holding <= bus.wdata;
            hold_full <= 1'b1;
         end
         if (baud_tick)
            tx_os <= tx_os + 4'h1;
         // The shifter ignores the break bit, so characters still time a break.
         case (tx_state) // RULE_11
            TX_IDLE: tx_line <= 1'b1;
            TX_START:
               if (tx_bit_end)
               begin
                  tx_line <= tx_shift[0]; // RULE_15
                  tx_bit <= 3'd0;
                  tx_state <= TX_DATA;
               end
            TX_DATA:
               if (tx_bit_end)
               begin
                  tx_shift <= {1'b0, tx_shift[7:1]};
                  tx_bit <= tx_bit + 3'd1;
                  if (tx_bit == fmt.data_bits_m1)
                  begin
                     tx_line <= fmt.parity_on ? tx_parity : 1'b1; // RULE_07
                     tx_half <= 2'd0;
                     tx_state <= fmt.parity_on ? TX_PARITY : TX_STOP;
                  end
                  else
                     tx_line <= tx_shift[1];
               end
            TX_PARITY:
               if (tx_bit_end)
               begin
                  tx_line <= 1'b1;
                  tx_half <= 2'd0;
                  tx_state <= TX_STOP;
               end
            TX_STOP:
               if (tx_stop_go) // RULE_05
                  tx_state <= TX_IDLE;
               else if (tx_bit_end || tx_half_end)
                  tx_half <= tx_half + 2'h1;
            default: tx_state <= TX_IDLE;
         endcase
         // Reloading at the last stop step keeps back-to-back characters free of idle gaps.
         if (tx_load)
         begin
            tx_shift <= transmit_holding;
            tx_parity <= parity_of(transmit_holding, fmt);
            hold_full <= 1'b0;
            tx_line <= 1'b0;
            tx_os <= 4'h0;
            tx_state <= TX_START;
         end
      end
   end

   assign holding_empty_flag = !hold_full;
   assign transmitter_idle_flag = !hold_full && (tx_state == TX_IDLE);
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         serial_out_line <= 1'b1;
      else
         serial_out_line <= line_control[LCR_BREAK] ? 1'b0 : tx_line; // RULE_10
   end

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Receiver, sampling at mid-bit on the 16x tick.
   typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} ulf_rx_state_t;
   ulf_rx_state_t rx_state;
   logic [7:0] rx_shift;
   logic [2:0] rx_bit;
   logic [3:0] rx_os;
   logic rx_parity;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         sin_meta <= 1'b1;
         sin_sync <= 1'b1;
      end
      else
      begin
         sin_meta <= serial_in_line;
         sin_sync <= sin_meta;
      end
   end

   wire rx_sample = baud_tick && (rx_os == OVERSAMPLE_MID);
   wire rx_done = rx_sample && (rx_state == RX_STOP);
   wire next_framing = !sin_sync; // RULE_06

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         rx_state <= RX_IDLE;
         rx_shift <= 8'h00;
         rx_bit <= 3'd0;
         rx_os <= 4'h0;
         rx_parity <= 1'b0;
         receive_buffer <= 8'h00;
         data_ready <= 1'b0;
         parity_err <= 1'b0;
         framing_err <= 1'b0;
      end
      else
      begin
         if (baud_tick)
            rx_os <= rx_os + 4'h1;
         // A completed character wins over a same-cycle read.
         if (rd_rbr && !rx_done)
            data_ready <= 1'b0;
         if (rd_lsr && !rx_done)
         begin
            parity_err <= 1'b0;
            framing_err <= 1'b0;
         end
         case (rx_state)
            RX_IDLE:
               if (baud_tick && !sin_sync)
               begin
                  rx_os <= 4'h1;
                  rx_state <= RX_START;
               end
            RX_START:
               if (rx_sample)
               begin
                  rx_bit <= 3'd0;
                  rx_shift <= 8'h00;
                  rx_state <= sin_sync ? RX_IDLE : RX_DATA;
               end
            RX_DATA:
               if (rx_sample)
               begin
                  rx_shift[rx_bit] <= sin_sync; // RULE_15
                  rx_bit <= rx_bit + 3'd1;
                  if (rx_bit == fmt.data_bits_m1)
                     rx_state <= fmt.parity_on ? RX_PARITY : RX_STOP;
               end
            RX_PARITY:
               if (rx_sample)
               begin
                  rx_parity <= sin_sync; // RULE_07
                  rx_state <= RX_STOP;
               end
            RX_STOP:
               if (rx_sample)
               begin
                  receive_buffer <= rx_shift;
                  data_ready <= 1'b1;
                  framing_err <= next_framing; // RULE_06
                  if (fmt.parity_on && (rx_parity != parity_of(rx_shift, fmt)))
                     parity_err <= 1'b1; // RULE_08
                  rx_state <= RX_IDLE;
               end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end
endmodule // ulf_channel

// *** src/ulf_pkg.sv ***
// Package of register offsets, line-control fields and format types for the serial channel.
package ulf_pkg;
   localparam logic [2:0] OFS_DATA = 3'h0;
   localparam logic [2:0] OFS_INT_ENABLE = 3'h1;
   localparam logic [2:0] OFS_INT_ID = 3'h2;
   localparam logic [2:0] OFS_LINE_CONTROL = 3'h3;
   localparam logic [2:0] OFS_MODEM_CONTROL = 3'h4;
   localparam logic [2:0] OFS_LINE_STATUS = 3'h5;
   localparam logic [2:0] OFS_MODEM_STATUS = 3'h6;
   localparam logic [2:0] OFS_SCRATCH = 3'h7;
   localparam int LCR_LEN_LO = 0;
   localparam int LCR_STOP = 2;
   localparam int LCR_PAR_EN = 3;
   localparam int LCR_EVEN = 4;
   localparam int LCR_STICK = 5;
   localparam int LCR_BREAK = 6;
   localparam int LCR_DIV_ACCESS = 7;
   localparam int LSR_DATA_READY = 0;
   localparam int LSR_PARITY_ERR = 2;
   localparam int LSR_FRAMING_ERR = 3;
   localparam int LSR_HOLD_EMPTY = 5;
   localparam int LSR_TX_IDLE = 6;
   localparam logic [7:0] RST_LINE_CONTROL = 8'h00;
   localparam logic [7:0] RST_INT_ENABLE = 8'h00;
   localparam logic [7:0] RST_MODEM_CONTROL = 8'h00;
   localparam logic [7:0] RST_SCRATCH = 8'h00;
   localparam logic [7:0] RST_DIV_LOW = 8'h01;
   localparam logic [7:0] RST_DIV_HIGH = 8'h00;
   localparam logic [7:0] INT_ID_NONE = 8'h01;
   localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
   localparam logic [3:0] OVERSAMPLE_MID = 4'h7;
   typedef struct packed {
      logic [2:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } ulf_bus_t;
   typedef struct packed {
      logic [2:0] data_bits_m1;
      logic parity_on;
      logic parity_bit_fixed;
      logic fixed_value;
      logic even;
      logic [1:0] stop_halves_m2;
   } ulf_format_t;
endpackage

// *** tb/uart_register_decode_line_format_test.sv ***
// Self-checking bench of the serial channel against a far-side line model.
`timescale 1ns/1ps
module uart_register_decode_line_format_test
   import ulf_pkg::*;
;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   ulf_bus_t bus = '0;
   logic [7:0] reg_rdata;
   logic serial_in_line, serial_out_line, baud_clock_output;
   logic holding_empty_flag, transmitter_idle_flag;
   int n_errors = 0;
   int total_checks = 0;
   always #12.5 sys_clk = ~sys_clk;
   ulf_channel i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(bus.addr),
      .reg_rd(bus.rd), .reg_wr(bus.wr), .reg_wdata(bus.wdata), .reg_rdata(reg_rdata),
      .serial_in_line(serial_in_line), .serial_out_line(serial_out_line),
      .baud_clock_output(baud_clock_output), .holding_empty_flag(holding_empty_flag),
      .transmitter_idle_flag(transmitter_idle_flag));
   ulf_serial_peer i_peer (.sys_clk(sys_clk), .tx_line(serial_out_line),
      .rx_line(serial_in_line));
   ////////////////////////////////////////
   task automatic print_verdict;
      if (n_errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input logic [11:0] m);
      total_checks++;
      if ((got & m) !== (exp & m))
      begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, got & m, exp & m);
      end
   endtask
   task automatic chk_n(input int got, input int exp);
      total_checks++;
      if (got != exp)
      begin
         n_errors++;
         $display("BAD %0t count %0d want %0d", $time, got, exp);
      end
   endtask
   task automatic stall(input logic hit);
      if (!hit)
      begin
         n_errors++;
         $display("BAD %0t wait ran out", $time);
         print_verdict();
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      bus = '{a, 1'b0, 1'b1, d};
      @(negedge sys_clk);
      bus.wr = 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
      @(negedge sys_clk);
      bus = '{a, 1'b1, 1'b0, 8'h00};
      @(negedge sys_clk);
      bus.rd = 1'b0;
      chk(reg_rdata, e, m);
   endtask
   // Idle (1) or holding empty (0); software must see these before reloading or breaking.
   task automatic wait_up(input logic idle, output int t);
      t = 0;
      while ((idle ? transmitter_idle_flag : holding_empty_flag) !== 1'b1 && t < 3000)
         @(negedge sys_clk) t++;
      stall(t < 3000);
   endtask
   ////////////////////////////////////////
   task automatic t_regs;
      rd(OFS_LINE_CONTROL, RST_LINE_CONTROL, 8'hFF);
      rd(OFS_INT_ENABLE, RST_INT_ENABLE, 8'hFF);
      rd(OFS_MODEM_CONTROL, RST_MODEM_CONTROL, 8'hFF);
      rd(OFS_INT_ID, INT_ID_NONE, 8'hFF);
      rd(OFS_LINE_STATUS, 8'h60, 8'h6D);
      wr(OFS_SCRATCH, 8'hA5);
      wr(OFS_MODEM_STATUS, 8'hFF);
      rd(OFS_MODEM_STATUS, 8'h00, 8'hFF);
      rd(OFS_SCRATCH, 8'hA5, 8'hFF);
      wr(OFS_LINE_CONTROL, 8'h80);
      rd(OFS_DATA, RST_DIV_LOW, 8'hFF);
      rd(OFS_INT_ENABLE, RST_DIV_HIGH, 8'hFF);
      wr(OFS_INT_ENABLE, 8'h34);
      rd(OFS_INT_ENABLE, 8'h34, 8'hFF);
      rd(OFS_LINE_CONTROL, 8'h80, 8'hFF);
      wr(OFS_INT_ENABLE, 8'h00);
      wr(OFS_LINE_CONTROL, 8'h03);
      wr(OFS_INT_ENABLE, 8'hFF);
      rd(OFS_INT_ENABLE, 8'h0F, 8'hFF);
      wr(OFS_MODEM_CONTROL, 8'hFF);
      rd(OFS_MODEM_CONTROL, 8'h1F, 8'hFF);
      wr(OFS_MODEM_CONTROL, 8'h00);
   endtask
   task automatic t_tx;
      logic [7:0] fm [8];
      logic [11:0] b, e;
      logic [7:0] d;
      logic ok;
      int n, p, g, t;
      fm = '{8'h00, 8'h04, 8'h05, 8'h1A, 8'h0B, 8'h2B, 8'h3B, 8'h07};
      for (int i = 0; i < 8; i++)
      begin
         n = 5 + fm[i][1:0];
         p = fm[i][3];
         d = 8'hA6 >> (8 - n);
         wait_up(1'b1, t);
         wr(OFS_LINE_CONTROL, fm[i]);
         fork
            i_peer.grab(n + p + 1, b, g, ok);
            begin
               wr(OFS_DATA, d);
               wait_up(1'b0, t);
               wr(OFS_DATA, d);
            end
         join
         stall(ok);
         e = (12'hFFF << n) | d;
         if (p)
            e[n] = fm[i][5] ? ~fm[i][4] : ^d ^ ~fm[i][4];
         chk(b, e, (12'h001 << (n + p + 1)) - 12'h001);
         chk_n(g, 16 * (1 + n + p) + (fm[i][2] ? (n == 5 ? 24 : 32) : 16));
      end
   endtask
   task automatic t_rx;
      wr(OFS_LINE_CONTROL, 8'h1B);
      i_peer.send({3'h7, ^8'h3C, 8'h3C}, 10);
      repeat (24) @(negedge sys_clk);
      rd(OFS_LINE_STATUS, 8'h01, 8'h0D);
      rd(OFS_DATA, 8'h3C, 8'hFF);
      rd(OFS_LINE_STATUS, 8'h00, 8'h01);
      i_peer.send({3'h7, ~^8'h3C, 8'h3C}, 10);
      repeat (24) @(negedge sys_clk);
      rd(OFS_LINE_STATUS, 8'h05, 8'h0D);
      i_peer.send({3'h6, ^8'h3C, 8'h3C}, 10);
      repeat (24) @(negedge sys_clk);
      rd(OFS_LINE_STATUS, 8'h09, 8'h0D);
      wr(OFS_LINE_CONTROL, 8'h07);
      // A low stop bit looks like a new start; let that false character finish first.
      repeat (160) @(negedge sys_clk);
      i_peer.send({4'hF, 8'h5A}, 9);
      i_peer.send({4'hF, 8'hC3}, 9);
      repeat (24) @(negedge sys_clk);
      rd(OFS_LINE_STATUS, 8'h01, 8'h0D);
      rd(OFS_DATA, 8'hC3, 8'hFF);
   endtask
   task automatic t_brk;
      int t;
      wait_up(1'b1, t);
      wr(OFS_LINE_CONTROL, 8'h43);
      @(negedge sys_clk);
      chk(serial_out_line, 12'h0, 12'h1);
      wr(OFS_DATA, 8'h81);
      chk(transmitter_idle_flag, 12'h0, 12'h1);
      wait_up(1'b1, t);
      chk(t > 140, 12'h1, 12'h1);
      chk(serial_out_line, 12'h0, 12'h1);
      wr(OFS_LINE_CONTROL, 8'h03);
      @(negedge sys_clk);
      chk(serial_out_line, 12'h1, 12'h1);
   endtask
   task automatic t_baud;
      int h;
      h = 0;
      repeat (64) @(negedge sys_clk) h += baud_clock_output;
      chk_n(h, 0);
      wr(OFS_LINE_CONTROL, 8'h83);
      wr(OFS_DATA, 8'h04);
      h = 0;
      repeat (64) @(negedge sys_clk) h += baud_clock_output;
      chk_n(h, 32);
      wr(OFS_DATA, 8'h01);
      wr(OFS_LINE_CONTROL, 8'h03);
   endtask
   initial
   begin
      repeat (10) @(negedge sys_clk);
      sys_rst = 1'b0;
      t_regs();
      t_tx();
      t_rx();
      t_brk();
      t_baud();
      print_verdict();
   end
endmodule // uart_register_decode_line_format_test

// *** tb/ulf_channel_sva.sv ***
// Checker of register decode, break forcing and baud output at the channel ports.
`timescale 1ns/1ps
module ulf_channel_sva
   import ulf_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [2:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic serial_in_line,
   input wire logic serial_out_line,
   input wire logic baud_clock_output,
   input wire logic holding_empty_flag,
   input wire logic transmitter_idle_flag
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   logic [7:0] lcr_q, dll_q, dlm_q, scr_q;
   wire dla = lcr_q[LCR_DIV_ACCESS];
   wire brk = lcr_q[LCR_BREAK];
   wire wr0 = reg_wr && reg_addr == OFS_DATA;
   wire wr1 = reg_wr && reg_addr == OFS_INT_ENABLE;
   wire [7:0] div_sel = reg_addr[0] ? dlm_q : dll_q;
   wire [7:0] fix_sel = reg_addr == OFS_SCRATCH ? scr_q : lcr_q;
   wire fix_hit = reg_addr == OFS_SCRATCH || reg_addr == OFS_LINE_CONTROL;
   ////////////////////////////////////////
   always_ff @(posedge sys_clk)
      if (sys_rst) lcr_q <= RST_LINE_CONTROL;
      else if (reg_wr && reg_addr == OFS_LINE_CONTROL) lcr_q <= reg_wdata;
   always_ff @(posedge sys_clk)
      if (sys_rst) scr_q <= RST_SCRATCH;
      else if (reg_wr && reg_addr == OFS_SCRATCH) scr_q <= reg_wdata;
   always_ff @(posedge sys_clk)
      if (sys_rst) dll_q <= RST_DIV_LOW;
      else if (wr0 && dla) dll_q <= reg_wdata;
   always_ff @(posedge sys_clk)
      if (sys_rst) dlm_q <= RST_DIV_HIGH;
      else if (wr1 && dla) dlm_q <= reg_wdata;
   ////////////////////////////////////////
   property p_map_rd; fix_hit && !reg_wr |=> reg_rdata == $past(fix_sel); endproperty
   a_map_rd: assert property (p_map_rd) else $error("fixed offset read wrong");
   property p_id_rd; reg_addr == OFS_INT_ID && !dla |=> reg_rdata == INT_ID_NONE; endproperty
   a_id_rd: assert property (p_id_rd) else $error("offset 2 read wrong");
   property p_div_rd; dla && reg_addr[2:1] == 2'b00 && !reg_wr |=> reg_rdata == $past(div_sel);
   endproperty
   a_div_rd: assert property (p_div_rd) else $error("divisor read wrong");
   property p_hold_wr; wr0 && !dla |=> !holding_empty_flag && !transmitter_idle_flag; endproperty
   a_hold_wr: assert property (p_hold_wr) else $error("holding load missed");
   property p_div_wr; wr0 && dla && holding_empty_flag |=> holding_empty_flag; endproperty
   a_div_wr: assert property (p_div_wr) else $error("divisor write hit holding");
   property p_brk_low; brk && $past(brk) |-> !serial_out_line; endproperty
   a_brk_low: assert property (p_brk_low) else $error("break not forcing line");
   property p_brk_tx; brk && wr0 && !dla |=> !transmitter_idle_flag; endproperty
   a_brk_tx: assert property (p_brk_tx) else $error("shifter stopped in break");
   property p_idle_hi; (!brk && transmitter_idle_flag) [*3] |-> serial_out_line; endproperty
   a_idle_hi: assert property (p_idle_hi) else $error("idle line not high");
   property p_baud_off; !dla |-> !baud_clock_output; endproperty
   a_baud_off: assert property (p_baud_off) else $error("baud shown without access");
   c_brk: cover property (brk && wr0);
endmodule // ulf_channel_sva
bind ulf_channel ulf_channel_sva i_sva (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .serial_in_line(serial_in_line), .serial_out_line(serial_out_line),
   .baud_clock_output(baud_clock_output), .holding_empty_flag(holding_empty_flag),
   .transmitter_idle_flag(transmitter_idle_flag));

// *** tb/ulf_serial_peer.sv ***
// Far-side serial line model: samples frames sent by the channel and sends frames to it.
`timescale 1ns/1ps
module ulf_serial_peer
(
   input wire logic sys_clk,
   input wire logic tx_line,
   output logic rx_line
);
   // Divisor 1 is assumed, so one bit lasts 16 clocks; a slower divisor breaks both tasks.
   initial rx_line = 1'b1;
   ////////////////////////////////////////
   task automatic fall(inout int t);
      while (tx_line !== 1'b0 && t < 4000) @(posedge sys_clk) t++;
   endtask
   task automatic grab(input int nb, output logic [11:0] bits, output int gap, output logic ok);
      int t;
      t = 0;
      bits = 12'hFFF;
      fall(t);
      repeat (8) @(posedge sys_clk);
      for (int k = 0; k < nb; k++)
      begin
         repeat (16) @(posedge sys_clk);
         bits[k] = tx_line;
      end
      gap = 8 + 16 * nb;
      fall(gap);
      ok = t < 4000 && gap < 4000;
   endtask
   task automatic send(input logic [11:0] bits, input int nb);
      @(posedge sys_clk) rx_line <= 1'b0;
      repeat (15) @(posedge sys_clk);
      for (int k = 0; k < nb; k++)
      begin
         @(posedge sys_clk) rx_line <= bits[k];
         repeat (15) @(posedge sys_clk);
      end
      @(posedge sys_clk) rx_line <= 1'b1;
   endtask
endmodule // ulf_serial_peer
